//--- logic/rhtc_params.svh
// Constants for the tunnel command handler and its host end
`ifndef RHTC_PARAMS_SVH
`define RHTC_PARAMS_SVH
`define RHTC_CLK_NS      5
`define RHTC_TICK_NS     1000
`define RHTC_TICK_CYC    (`RHTC_TICK_NS / `RHTC_CLK_NS)
`define RHTC_JIS_READ    8'h06
`define RHTC_JIS_WRITE   8'h08
`define RHTC_TB_READ     8'hb0
`define RHTC_TB_WRITE    8'hd6
`define RHTC_CMD_INQ     8'h28
`define RHTC_CMD_ANS_OK  8'hf8
`define RHTC_CMD_ANS_ERR 8'he8
`define RHTC_CLA_OK      8'h00
`define RHTC_CNT_MIN     8'h01
`define RHTC_CNT_MAX     8'h0f
`define RHTC_IDX_CLA     10'h000
`define RHTC_IDX_INS     10'h001
`define RHTC_IDX_P1      10'h002
`define RHTC_IDX_P2      10'h003
`define RHTC_IDX_LE      10'h004
`define RHTC_IDX_K       10'h009
`define RHTC_IDX_SVC     10'h00a
`define RHTC_STAT_OK     8'h00
`define RHTC_STAT_BUSY   8'h01
`define RHTC_ADDR_TAG    2'b01
`define RHTC_INQ_LAST    3'h3
`endif

//--- logic/rhtc_pkg.sv
// Types for the two ends of the tunnel link: device states, host states, device command kind
package rhtc_pkg;
	typedef enum logic [2:0] {S_IDLE, S_WAITQ, S_CMD, S_REPLY, S_WAITA} rhtc_dev_st_t;
	typedef enum logic [1:0] {H_IDLE, H_SEND, H_DROP, H_READ} rhtc_host_st_t;
	typedef enum logic [1:0] {C_OTHER, C_INQ, C_ANS} rhtc_cmd_t;
endpackage : rhtc_pkg

//--- logic/rhtc_if.sv
// Byte-level tag-host serial link
`timescale 1ns/1ps
interface rhtc_if;
	logic       host_irq_out_n; // Tag interrupt, active low
	logic       sel_wr;         // Address matched, host write transfer
	logic       sel_rd;         // Address matched, host read transfer
	logic       h_valid;        // Host command byte valid
	logic [7:0] h_data;         // Host command byte
	logic       h_last;         // Last byte of command
	logic       h_ready;        // Tag takes command byte
	logic       d_valid;        // Reply byte valid
	logic [7:0] d_data;         // Reply byte
	logic       d_last;         // Last reply byte
	logic       d_ready;        // Host takes reply byte
	modport dev (output host_irq_out_n, d_valid, d_data, d_last, h_ready,
		input sel_wr, sel_rd, h_valid, h_data, h_last, d_ready);
	modport hst (input host_irq_out_n, d_valid, d_data, d_last, h_ready,
		output sel_wr, sel_rd, h_valid, h_data, h_last, d_ready);
endinterface : rhtc_if

//--- logic/rhtc_buf2.sv
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module rhtc_buf2 (
	input  wire logic       sys_clk_i,  // System clock
	input  wire logic       reset_n_i,  // Async reset, active low
	input  wire logic       in_valid_i, // Word offered
	input  wire logic [8:0] in_data_i,  // Word in
	output logic            in_ready_o, // Room for a word
	output logic            out_valid_o,// Word held
	output logic      [8:0] out_data_o, // Oldest word
	input  wire logic       out_ready_i // Drain takes word
);
	logic [8:0] mem_q [2];
	logic [8:0] mem_d [2];
	logic       wp_q, wp_d, rp_q, rp_d;
	logic [1:0] cnt_q, cnt_d;
	logic       push, pop;

	// Flags follow the count, so a stall fills it
	assign in_ready_o  = (cnt_q != 2'h2);
	assign out_valid_o = (cnt_q != 2'h0);
	assign out_data_o  = mem_q[rp_q];
	assign push        = in_valid_i && in_ready_o;
	assign pop         = out_valid_o && out_ready_i;

	// Pointer and count update
	always_comb begin
		mem_d = mem_q;
		wp_d  = wp_q;
		rp_d  = rp_q;
		cnt_d = cnt_q;
		if (push) begin
			mem_d[wp_q] = in_data_i;
			wp_d        = ~wp_q;
		end
		if (pop) begin
			rp_d = ~rp_q;
		end
		if (push && !pop) begin
			cnt_d = cnt_q + 2'h1;
		end else if (pop && !push) begin
			cnt_d = cnt_q - 2'h1;
		end
	end

	// State registers
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			mem_q[0] <= 9'h000;
			mem_q[1] <= 9'h000;
			wp_q     <= 1'b0;
			rp_q     <= 1'b0;
			cnt_q    <= 2'h0;
		end else begin
			mem_q <= mem_d;
			wp_q  <= wp_d;
			rp_q  <= rp_d;
			cnt_q <= cnt_d;
		end
	end
endmodule : rhtc_buf2

//--- logic/rhtc_device.sv
// Tag end: RF command parse, host notify, inquiry and result waits
// What this block does
// RL1: Time out missing inquiry or result commands
// RL2: Host command starts at address acknowledge
// RL3: Inquiry timer starts at interrupt fall
// RL4: Inquiry timeout sends error to reader
// RL5: Other host commands pause the count
// RL6: Result timer starts after inquiry reply
// RL7: Read codes 0x06 and 0xB0
// RL8: Write codes 0x08 and 0xD6
// RL9: Inquiry code is 0x28
// RL10: Result codes 0xF8 ok, 0xE8 fail
// RL11: Reader read layout: code, id, services, blocks
// RL12: Service count outside 1..15 is error
// RL13: Unequal service identifiers give error
// RL14: Block count outside 1..15 is error
// RL15: Class byte not zero is error for Type B reads; Type B writes still pass to the host
// RL16: Type B start address from P1, P2
// RL17: Reader keeps Le within 1..251
// RL18: Tunnel command pulls interrupt low
// RL19: Read address match releases interrupt
// RL20: Inquiry reply: status, address, length
// RL21: Failure result carries no data
// RL22: Result timeout sends error to reader
// RL23: Valid inquiry or result stops timer
`timescale 1ns/1ps
`include "rhtc_params.svh"
module rhtc_device (
	input  wire logic        sys_clk_i,            // System clock, 200 MHz
	input  wire logic        reset_n_i,            // Async reset, active low
	rhtc_if.dev              bus,                  // Serial link to host
	input  wire logic        rf_valid_i,           // Reader byte valid
	input  wire logic  [7:0] rf_byte_i,            // Reader byte
	input  wire logic        rf_last_i,            // Last byte of reader frame
	input  wire logic        rf_typeb_i,           // Frame is Type B
	input  wire logic  [1:0] rf_mode_i,            // Plain or key mode
	input  wire logic [15:0] inquiry_wait_limit_i, // Inquiry wait, us ticks
	input  wire logic [15:0] result_wait_limit_i,  // Result wait, us ticks
	output logic             rf_data_valid_o,      // Result data byte valid
	output logic       [7:0] rf_data_o,            // Result data byte
	output logic             rf_resp_valid_o,      // Reader response pulse
	output logic             rf_resp_err_o,        // Response is an error
	output logic             timeout_o             // Wait expired pulse
);
	rhtc_pkg::rhtc_dev_st_t st_q, st_d, ret_q, ret_d;
	rhtc_pkg::rhtc_cmd_t    ct_q, ct_d;
	logic [7:0]  tdiv_q, tdiv_d;
	logic [9:0]  idx_q, idx_d;
	logic [7:0]  k_q, k_d, len_q, len_d;
	logic [15:0] sid_q, sid_d, cnt_q, cnt_d;
	logic [13:0] addr_q, addr_d;
	logic [1:0]  kind_q, kind_d, mode_q, mode_d;
	logic        bad_q, bad_d, first_q, first_d, aerr_q, aerr_d, irq_q, irq_d;
	logic [2:0]  ridx_q, ridx_d;
	logic        dv_q, dv_d, dl_q, dl_d, rv_q, rv_d, rsv_q, rsv_d, rse_q, rse_d;
	logic        to_q, to_d;
	logic [7:0]  dd_q, dd_d, rd_q, rd_d;
	logic        tick, bv, bpop, blast;
	logic [8:0]  bdat;
	logic [7:0]  bbyte;
	logic [9:0]  svc_end;
	logic [15:0] lim;

	// Frame kind: {read, write}
	function automatic logic [1:0] rhtc_kind(input logic typeb, input logic [7:0] b);
		if (typeb) begin
			rhtc_kind = {b == `RHTC_TB_READ, b == `RHTC_TB_WRITE};   // RL7 RL8
		end else begin
			rhtc_kind = {b == `RHTC_JIS_READ, b == `RHTC_JIS_WRITE}; // RL7 RL8
		end
	endfunction : rhtc_kind

	// Reply byte by position
	function automatic logic [7:0] rhtc_reply(input rhtc_pkg::rhtc_cmd_t ct,
		input logic [2:0] i, input logic [1:0] md, input logic [13:0] a, input logic [7:0] n);
		if (ct == rhtc_pkg::C_OTHER) begin
			rhtc_reply = `RHTC_STAT_BUSY;
		end else if (ct == rhtc_pkg::C_ANS || i == 3'h0) begin
			rhtc_reply = `RHTC_STAT_OK;
		end else if (i == 3'h1) begin
			rhtc_reply = {`RHTC_ADDR_TAG, md, a[11:8]}; // RL20
		end else if (i == 3'h2) begin
			rhtc_reply = a[7:0];                         // RL20
		end else begin
			rhtc_reply = n;                              // RL20
		end
	endfunction : rhtc_reply

	// Host bytes pass a small buffer so a slow drain loses nothing
	rhtc_buf2 u_buf (
		.sys_clk_i   (sys_clk_i),
		.reset_n_i   (reset_n_i),
		.in_valid_i  (bus.h_valid),
		.in_data_i   ({bus.h_last, bus.h_data}),
		.in_ready_o  (bus.h_ready),
		.out_valid_o (bv),
		.out_data_o  (bdat),
		.out_ready_i (bpop)
	);

	assign bpop    = (st_q == rhtc_pkg::S_CMD) && bv;
	assign bbyte   = bdat[7:0];
	assign blast   = bdat[8];
	assign tick    = (tdiv_q == 8'h00);
	assign svc_end = `RHTC_IDX_SVC + {1'b0, k_q, 1'b0};
	assign lim     = (st_q == rhtc_pkg::S_WAITA) ? result_wait_limit_i : inquiry_wait_limit_i;

	// Microsecond tick; waits count in ticks so limits stay 16 bits
	always_comb begin
		tdiv_d = tick ? 8'(`RHTC_TICK_CYC - 1) : tdiv_q - 8'h01;
	end

	// Main control
	always_comb begin
		st_d = st_q; ret_d = ret_q; ct_d = ct_q;
		idx_d = idx_q; k_d = k_q; len_d = len_q; sid_d = sid_q; cnt_d = cnt_q;
		addr_d = addr_q; kind_d = kind_q; mode_d = mode_q; bad_d = bad_q;
		first_d = first_q; aerr_d = aerr_q; irq_d = irq_q; ridx_d = ridx_q;
		dv_d = dv_q; dl_d = dl_q; dd_d = dd_q; rd_d = rd_q;
		rv_d = 1'b0; rsv_d = 1'b0; rse_d = rse_q; to_d = 1'b0;
		if (bus.sel_rd) begin
			irq_d = 1'b1; // RL19
		end
		case (st_q)
			rhtc_pkg::S_IDLE: begin
				if (bus.sel_wr) begin
					st_d    = rhtc_pkg::S_CMD;
					ret_d   = rhtc_pkg::S_IDLE;
					first_d = 1'b1;
				end else if (rf_valid_i) begin
					// Reader frame walk, one byte per cycle
					idx_d = idx_q + 10'h001;
					if (idx_q == `RHTC_IDX_CLA) begin
						kind_d = rhtc_kind(rf_typeb_i, rf_byte_i);
						bad_d  = rf_typeb_i && (rf_byte_i != `RHTC_CLA_OK); // RL15
						mode_d = rf_mode_i;
						addr_d = 14'h0000;
						len_d  = 8'h00;
					end
					if (rf_typeb_i) begin
						if (idx_q == `RHTC_IDX_INS) begin
							kind_d = rhtc_kind(1'b1, rf_byte_i); // RL7 RL8
						end else if (idx_q == `RHTC_IDX_P1) begin
							addr_d[13:8] = rf_byte_i[5:0]; // RL16
						end else if (idx_q == `RHTC_IDX_P2) begin
							addr_d[7:0] = rf_byte_i;       // RL16
						end else if (idx_q == `RHTC_IDX_LE) begin
							len_d = rf_byte_i; // RL17
						end
					end else if (idx_q == `RHTC_IDX_K) begin
						k_d = rf_byte_i; // RL11
						if (rf_byte_i < `RHTC_CNT_MIN || rf_byte_i > `RHTC_CNT_MAX) begin
							bad_d = 1'b1; // RL12
						end
					end else if (idx_q == `RHTC_IDX_SVC) begin
						sid_d[15:8] = rf_byte_i;
					end else if (idx_q == `RHTC_IDX_SVC + 10'h001) begin
						sid_d[7:0] = rf_byte_i;
					end else if (idx_q > `RHTC_IDX_SVC + 10'h001 && idx_q < svc_end) begin
						if (rf_byte_i != (idx_q[0] ? sid_q[7:0] : sid_q[15:8])) begin
							bad_d = 1'b1; // RL13
						end
					end else if (idx_q == svc_end) begin
						len_d = {rf_byte_i[3:0], 4'h0};
						if (rf_byte_i < `RHTC_CNT_MIN || rf_byte_i > `RHTC_CNT_MAX) begin
							bad_d = 1'b1; // RL14
						end
					end else if (idx_q == svc_end + 10'h002) begin
						addr_d = {2'b00, rf_byte_i, 4'h0};
					end
					if (rf_last_i) begin
						idx_d = 10'h000;
						if (kind_d[1] && bad_d) begin
							rsv_d = 1'b1; // RL12 RL13 RL14 RL15
							rse_d = 1'b1;
						end else if (kind_d != 2'b00) begin
							st_d  = rhtc_pkg::S_WAITQ;
							irq_d = 1'b0;  // RL18 RL3
							cnt_d = 16'h0000;
						end
					end
				end
			end
			rhtc_pkg::S_WAITQ, rhtc_pkg::S_WAITA: begin
				if (bus.sel_wr) begin
					st_d    = rhtc_pkg::S_CMD; // RL2 RL5
					ret_d   = st_q;
					first_d = 1'b1;
				end else if (tick) begin
					if (cnt_q >= lim) begin
						st_d  = rhtc_pkg::S_IDLE; // RL1 RL4 RL22
						rsv_d = 1'b1;
						rse_d = 1'b1;
						to_d  = 1'b1;
						irq_d = 1'b1;
					end else begin
						cnt_d = cnt_q + 16'h0001;
					end
				end
			end
			rhtc_pkg::S_CMD: begin
				if (bv) begin
					if (first_q) begin
						first_d = 1'b0;
						aerr_d  = (bbyte == `RHTC_CMD_ANS_ERR);
						if (ret_q == rhtc_pkg::S_WAITQ && bbyte == `RHTC_CMD_INQ) begin
							ct_d = rhtc_pkg::C_INQ; // RL9 RL23
						end else if (ret_q == rhtc_pkg::S_WAITA &&
							(bbyte == `RHTC_CMD_ANS_OK || bbyte == `RHTC_CMD_ANS_ERR)) begin
							ct_d = rhtc_pkg::C_ANS; // RL10 RL23
						end else begin
							ct_d = rhtc_pkg::C_OTHER;
						end
					end else if (ct_q == rhtc_pkg::C_ANS && !aerr_q) begin
						rv_d = 1'b1; // RL21
						rd_d = bbyte;
					end
					if (blast) begin
						st_d   = rhtc_pkg::S_REPLY;
						irq_d  = 1'b0;
						ridx_d = 3'h0;
					end
				end
			end
			rhtc_pkg::S_REPLY: begin
				if (bus.sel_rd && !dv_q) begin
					dv_d = 1'b1;
					dd_d = rhtc_reply(ct_q, 3'h0, mode_q, addr_q, len_q);
					dl_d = (ct_q != rhtc_pkg::C_INQ);
				end else if (dv_q && bus.d_ready) begin
					if (dl_q) begin
						dv_d = 1'b0;
						dl_d = 1'b0;
						if (ct_q == rhtc_pkg::C_INQ) begin
							st_d  = rhtc_pkg::S_WAITA; // RL6
							cnt_d = 16'h0000;
						end else if (ct_q == rhtc_pkg::C_ANS) begin
							st_d  = rhtc_pkg::S_IDLE;
							rsv_d = 1'b1;
							rse_d = aerr_q;
						end else begin
							st_d = ret_q; // RL5
						end
					end else begin
						ridx_d = ridx_q + 3'h1;
						dd_d   = rhtc_reply(ct_q, ridx_q + 3'h1, mode_q, addr_q, len_q);
						dl_d   = (ridx_q + 3'h1 == `RHTC_INQ_LAST);
					end
				end
			end
			default: begin
				st_d = rhtc_pkg::S_IDLE;
			end
		endcase
	end

	// Registers; interrupt rests high
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			st_q <= rhtc_pkg::S_IDLE; ret_q <= rhtc_pkg::S_IDLE; ct_q <= rhtc_pkg::C_OTHER;
			tdiv_q <= 8'h00; idx_q <= 10'h000; k_q <= 8'h00; len_q <= 8'h00;
			sid_q <= 16'h0000; cnt_q <= 16'h0000; addr_q <= 14'h0000;
			kind_q <= 2'h0; mode_q <= 2'h0; bad_q <= 1'b0; first_q <= 1'b0;
			aerr_q <= 1'b0; irq_q <= 1'b1; ridx_q <= 3'h0;
			dv_q <= 1'b0; dl_q <= 1'b0; dd_q <= 8'h00; rd_q <= 8'h00;
			rv_q <= 1'b0; rsv_q <= 1'b0; rse_q <= 1'b0; to_q <= 1'b0;
		end else begin
			st_q <= st_d; ret_q <= ret_d; ct_q <= ct_d;
			tdiv_q <= tdiv_d; idx_q <= idx_d; k_q <= k_d; len_q <= len_d;
			sid_q <= sid_d; cnt_q <= cnt_d; addr_q <= addr_d;
			kind_q <= kind_d; mode_q <= mode_d; bad_q <= bad_d; first_q <= first_d;
			aerr_q <= aerr_d; irq_q <= irq_d; ridx_q <= ridx_d;
			dv_q <= dv_d; dl_q <= dl_d; dd_q <= dd_d; rd_q <= rd_d;
			rv_q <= rv_d; rsv_q <= rsv_d; rse_q <= rse_d; to_q <= to_d;
		end
	end

	assign bus.host_irq_out_n = irq_q;
	assign bus.d_valid        = dv_q;
	assign bus.d_data         = dd_q;
	assign bus.d_last         = dl_q;
	assign rf_data_valid_o    = rv_q;
	assign rf_data_o          = rd_q;
	assign rf_resp_valid_o    = rsv_q;
	assign rf_resp_err_o      = rse_q;
	assign timeout_o          = to_q;
endmodule : rhtc_device

//--- logic/rhtc_host.sv
// Host end: sends commands, fetches replies when interrupted
`timescale 1ns/1ps
`include "rhtc_params.svh"
module rhtc_host (
	input  wire logic       sys_clk_i,     // System clock
	input  wire logic       reset_n_i,     // Async reset, active low
	rhtc_if.hst             bus,           // Serial link to tag
	input  wire logic       inquiry_req_i, // Send inquiry, pulse
	input  wire logic       cmd_valid_i,   // Command byte offered
	input  wire logic [7:0] cmd_byte_i,    // Command byte
	input  wire logic       cmd_last_i,    // Last command byte
	output logic            cmd_ready_o,   // Command byte taken
	output logic            rsp_valid_o,   // Reply byte pulse
	output logic      [7:0] rsp_byte_o,    // Reply byte
	output logic            rsp_last_o,    // Last reply byte
	output logic            irq_seen_o     // Tag interrupt is low
);
	rhtc_pkg::rhtc_host_st_t st_q, st_d;
	logic       sw_q, sw_d, sr_q, sr_d, hv_q, hv_d, hl_q, hl_d, dr_q, dr_d;
	logic       rdy_q, rdy_d, fst_q, fst_d, drop_q, drop_d, pend_q, pend_d;
	logic       rv_q, rv_d, rl_q, rl_d, irq_q;
	logic [7:0] hd_q, hd_d, rb_q, rb_d;
	logic       take;

	// One-byte holding stage; half rate keeps ready a plain flop
	assign take = cmd_valid_i && rdy_q;

	// Transfer control
	always_comb begin
		st_d = st_q; sw_d = 1'b0; sr_d = 1'b0; hv_d = hv_q; hl_d = hl_q; hd_d = hd_q;
		dr_d = dr_q; rdy_d = rdy_q; fst_d = fst_q; drop_d = drop_q; pend_d = pend_q;
		rv_d = 1'b0; rl_d = rl_q; rb_d = rb_q;
		case (st_q)
			rhtc_pkg::H_IDLE: begin
				if (pend_q && !bus.host_irq_out_n) begin
					sr_d = 1'b1;
					dr_d = 1'b1;
					st_d = rhtc_pkg::H_READ;
				end else if (!pend_q && inquiry_req_i) begin
					sw_d = 1'b1;
					hv_d = 1'b1;
					hd_d = `RHTC_CMD_INQ; // RL9
					hl_d = 1'b1;
					st_d = rhtc_pkg::H_SEND;
				end else if (!pend_q && cmd_valid_i) begin
					sw_d  = 1'b1;
					rdy_d = 1'b1;
					fst_d = 1'b1;
					st_d  = rhtc_pkg::H_SEND;
				end
			end
			rhtc_pkg::H_SEND: begin
				if (take) begin
					rdy_d  = 1'b0;
					hv_d   = 1'b1;
					hd_d   = cmd_byte_i;
					fst_d  = 1'b0;
					drop_d = fst_q && cmd_byte_i == `RHTC_CMD_ANS_ERR && !cmd_last_i; // RL10
					hl_d   = cmd_last_i || (fst_q && cmd_byte_i == `RHTC_CMD_ANS_ERR); // RL21
				end else if (hv_q && bus.h_ready) begin
					hv_d = 1'b0;
					if (hl_q) begin
						pend_d = 1'b1;
						rdy_d  = drop_q;
						st_d   = drop_q ? rhtc_pkg::H_DROP : rhtc_pkg::H_IDLE;
					end else begin
						rdy_d = 1'b1;
					end
				end
			end
			rhtc_pkg::H_DROP: begin
				if (take && cmd_last_i) begin
					rdy_d  = 1'b0;
					drop_d = 1'b0;
					st_d   = rhtc_pkg::H_IDLE;
				end
			end
			rhtc_pkg::H_READ: begin
				if (bus.d_valid && dr_q) begin
					rv_d = 1'b1;
					rb_d = bus.d_data;
					rl_d = bus.d_last;
					if (bus.d_last) begin
						dr_d   = 1'b0;
						pend_d = 1'b0;
						st_d   = rhtc_pkg::H_IDLE;
					end
				end
			end
			default: begin
				st_d = rhtc_pkg::H_IDLE;
			end
		endcase
	end

	// Registers
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			st_q <= rhtc_pkg::H_IDLE; sw_q <= 1'b0; sr_q <= 1'b0; hv_q <= 1'b0;
			hl_q <= 1'b0; hd_q <= 8'h00; dr_q <= 1'b0; rdy_q <= 1'b0; fst_q <= 1'b0;
			drop_q <= 1'b0; pend_q <= 1'b0; rv_q <= 1'b0; rl_q <= 1'b0;
			rb_q <= 8'h00; irq_q <= 1'b0;
		end else begin
			st_q <= st_d; sw_q <= sw_d; sr_q <= sr_d; hv_q <= hv_d;
			hl_q <= hl_d; hd_q <= hd_d; dr_q <= dr_d; rdy_q <= rdy_d; fst_q <= fst_d;
			drop_q <= drop_d; pend_q <= pend_d; rv_q <= rv_d; rl_q <= rl_d;
			rb_q <= rb_d; irq_q <= !bus.host_irq_out_n;
		end
	end

	assign bus.sel_wr  = sw_q;
	assign bus.sel_rd  = sr_q;
	assign bus.h_valid = hv_q;
	assign bus.h_data  = hd_q;
	assign bus.h_last  = hl_q;
	assign bus.d_ready = dr_q;
	assign cmd_ready_o = rdy_q;
	assign rsp_valid_o = rv_q;
	assign rsp_byte_o  = rb_q;
	assign rsp_last_o  = rl_q;
	assign irq_seen_o  = irq_q;
endmodule : rhtc_host

//--- testbench/rhtc_link_chk.sv
// Checks on the tag-host serial link
`timescale 1ns/1ps
module rhtc_link_chk (
	input  wire logic       sys_clk_i,      // System clock
	input  wire logic       reset_n_i,      // Async reset, active low
	input  wire logic       host_irq_out_n, // Tag interrupt, active low
	input  wire logic       sel_rd,         // Host read select
	input  wire logic       h_valid,        // Command byte valid
	input  wire logic       h_last,         // Command end
	input  wire logic       h_ready,        // Command byte taken
	input  wire logic       d_valid,        // Reply byte valid
	input  wire logic [7:0] d_data,         // Reply byte
	input  wire logic       d_last,         // Reply end
	input  wire logic       d_ready         // Reply byte taken
);
	logic [1:0] cnt_q, cnt_d;
	logic [7:0] b1_q, b1_d;

	// Reply byte position and second byte
	always_comb begin
		cnt_d = cnt_q;
		b1_d  = b1_q;
		if (d_valid && d_ready) begin
			cnt_d = d_last ? 2'h0 : cnt_q + 2'h1;
			if (cnt_q == 2'h1) b1_d = d_data;
		end
	end

	// Registers only
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cnt_q <= 2'h0;
			b1_q  <= 8'h00;
		end else begin
			cnt_q <= cnt_d;
			b1_q  <= b1_d;
		end
	end

	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!reset_n_i);

	// Interrupt release and reply start follow the read select
	irq_release_a: assert property (sel_rd |=> host_irq_out_n)
		else $error("interrupt held after read select");
	reply_start_a: assert property (sel_rd |=> d_valid)
		else $error("reply did not start after read select");
	reply_cause_a: assert property ($rose(d_valid) |-> $past(sel_rd))
		else $error("reply started without read select");
	reply_irq_a: assert property (d_valid |-> host_irq_out_n)
		else $error("interrupt low during reply");
	// Reply held while stalled, and laid out as status, address, length
	reply_hold_a: assert property (d_valid && !d_ready |=> d_valid && $stable(d_data) && $stable(d_last))
		else $error("reply byte changed while stalled");
	reply_len_a: assert property (d_valid && d_last |-> cnt_q == 2'h0 || cnt_q == 2'h3)
		else $error("reply length not one or four bytes");
	addr_tag_a: assert property (d_valid && d_ready && d_last && cnt_q == 2'h3 |-> b1_q[7:6] == 2'b01)
		else $error("address tag bits wrong");
	reply_status_a: assert property (d_valid && cnt_q == 2'h0 |-> d_data inside {8'h00, 8'h01})
		else $error("unknown status byte");
	// Host command end brings an interrupt
	cmd_irq_a: assert property (h_valid && h_ready && h_last |-> ##[1:8] !host_irq_out_n)
		else $error("no interrupt after host command");
endmodule : rhtc_link_chk

//--- testbench/tb.sv
// Self-checking bench for both ends of the tunnel link
`timescale 1ns/1ps
`include "rhtc_params.svh"
module tb;
	logic        clk, rst_n, rf_v, rf_l, rf_b, inq, cv, cl, rdv, rrv, rerr, tmo, crdy;
	logic        rsp_v, rsp_l, seen, rv_d;
	logic [7:0]  rf_d, cb, rsp_b, rdat, k, m, b, p1, p2, le;
	logic [1:0]  md;
	logic [15:0] ql, al;
	logic [7:0]  fr[$], rq[$], dq[$];
	logic        eq[$];
	logic [31:0] seed = 32'h336365be;
	int          num_errors = 0, checks_done = 0, tos = 0, cyc = 0, t0;

	rhtc_if link ();
	rhtc_device u_rhtc_device (.sys_clk_i(clk), .reset_n_i(rst_n), .bus(link.dev), .rf_valid_i(rf_v),
		.rf_byte_i(rf_d), .rf_last_i(rf_l), .rf_typeb_i(rf_b), .rf_mode_i(md),
		.inquiry_wait_limit_i(ql), .result_wait_limit_i(al), .rf_data_valid_o(rdv),
		.rf_data_o(rdat), .rf_resp_valid_o(rrv), .rf_resp_err_o(rerr), .timeout_o(tmo));
	rhtc_host u_rhtc_host (.sys_clk_i(clk), .reset_n_i(rst_n), .bus(link.hst), .inquiry_req_i(inq),
		.cmd_valid_i(cv), .cmd_byte_i(cb), .cmd_last_i(cl), .cmd_ready_o(crdy),
		.rsp_valid_o(rsp_v), .rsp_byte_o(rsp_b), .rsp_last_o(rsp_l), .irq_seen_o(seen));
	rhtc_link_chk u_chk (.sys_clk_i(clk), .reset_n_i(rst_n), .host_irq_out_n(link.host_irq_out_n),
		.sel_rd(link.sel_rd), .h_valid(link.h_valid), .h_last(link.h_last), .h_ready(link.h_ready),
		.d_valid(link.d_valid), .d_data(link.d_data), .d_last(link.d_last), .d_ready(link.d_ready));

	// Clock, 5 ns period
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// Outputs sampled on the falling edge
	always @(negedge clk) begin
		cyc++;
		if (rv_d) eq.push_back(rerr);
		rv_d = rrv;
		if (rsp_v === 1'b1) rq.push_back(rsp_b);
		if (rdv === 1'b1) dq.push_back(rdat);
		if (tmo === 1'b1) tos++;
	end

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	// Expected second inquiry reply byte
	function automatic logic [7:0] exp_b1(input logic [1:0] mo, input logic [13:0] a);
		return {`RHTC_ADDR_TAG, mo, a[11:8]};
	endfunction : exp_b1

	// Reader read frame; bad spoils the last service
	function automatic void mk_jis(input logic [7:0] kk, mm, bb, input logic bad);
		fr = {`RHTC_JIS_READ};
		repeat (8) fr.push_back(8'(rnd()));
		fr.push_back(kk);
		for (int i = 0; i < kk; i++) begin
			fr.push_back(8'h09);
			fr.push_back((bad && i == kk - 1) ? 8'h01 : 8'h00);
		end
		fr.push_back(mm);
		fr.push_back(8'h80);
		fr.push_back(bb);
	endfunction : mk_jis

	task automatic wrap_up();
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : wrap_up

	task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
		checks_done++;
		if (g !== e) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask : chk8

	task automatic chk1(input string n, input logic e, input logic g);
		chk8(n, {7'h00, e}, {7'h00, g});
	endtask : chk1

	// Bounded wait; expiry fails the run
	task automatic wait_on(input int c, input int n, input int lim);
		int i;
		for (i = 0; i < lim; i++) begin
			if (c == 0 ? seen === 1'b1 : c == 1 ? rq.size() >= n : c == 2 ? eq.size() >= n
				: c == 3 ? tos >= n : crdy === 1'b1) break;
			@(negedge clk);
		end
		if (i == lim) begin
			num_errors++;
			$display("wrong value wait %0d expected done seen stuck", c);
			wrap_up();
		end
	endtask : wait_on

	// Reader frame from fr, one byte a cycle
	task automatic rf_send(input logic tb_b);
		rf_b = tb_b;
		foreach (fr[i]) begin
			rf_v = 1'b1;
			rf_d = fr[i];
			rf_l = (i == fr.size() - 1);
			@(negedge clk);
		end
		rf_v = 1'b0;
		rf_l = 1'b0;
	endtask : rf_send

	// Host command from fr, byte by byte
	task automatic h_send();
		foreach (fr[i]) begin
			cv = 1'b1;
			cb = fr[i];
			cl = (i == fr.size() - 1);
			wait_on(4, 0, 100);
			@(negedge clk);
		end
		cv = 1'b0;
		cl = 1'b0;
	endtask : h_send

	// Inquiry, reply, then result
	task automatic tunnel(input logic [13:0] a, input logic [7:0] len, res, input logic ca, via);
		int n;
		wait_on(0, 0, 40);
		chk1("irq", 1'b1, seen);
		rq.delete();
		dq.delete();
		eq.delete();
		fr = {`RHTC_CMD_INQ};
		if (via) h_send();
		else inq = 1'b1;
		@(negedge clk);
		inq = 1'b0;
		wait_on(1, 4, 200);
		chk8("status", `RHTC_STAT_OK, rq[0]);
		chk1("rsp_last", 1'b1, rsp_l);
		if (ca) chk8("addr_hi", exp_b1(md, a), rq[1]);
		if (ca) chk8("addr_lo", a[7:0], rq[2]);
		if (ca) chk8("len", len, rq[3]);
		n = int'(rnd() % 4) + 1;
		fr = {res};
		repeat (n) fr.push_back(8'(rnd()));
		h_send();
		wait_on(1, 5, 200);
		chk8("ans_status", `RHTC_STAT_OK, rq[4]);
		wait_on(2, 1, 100);
		chk1("resp_err", res == `RHTC_CMD_ANS_ERR, eq[0]);
		chk8("data_cnt", (res == `RHTC_CMD_ANS_OK) ? 8'(n) : 8'h00, 8'(dq.size()));
		foreach (dq[i]) chk8("data", fr[i + 1], dq[i]);
	endtask : tunnel

	// Expiry no sooner than the limit
	task automatic to_win(input int lim);
		tos = 0;
		eq.delete();
		wait_on(3, 1, (lim + 1) * 200 + 60);
		chk1("to_time", 1'b1, cyc - t0 >= lim * 200 - 4);
		wait_on(2, 1, 10);
		chk1("to_err", 1'b1, eq[0]);
		repeat (3) @(negedge clk);
		chk1("to_irq", 1'b0, seen);
	endtask : to_win

	initial begin
		{rf_v, rf_l, rf_b, inq, cv, cl, rv_d, rst_n} = 8'h00;
		{rf_d, cb, md} = 18'h00000;
		ql = 16'h0002;
		al = 16'h0003;
		repeat (16) @(negedge clk);
		rst_n = 1'b1;
		@(negedge clk);
		// Good reads, both results, both inquiry paths
		for (int i = 0; i < 4; i++) begin
			k = (i == 0) ? 8'h0f : (i == 1) ? 8'h01 : 8'(rnd() % 15 + 1);
			m = (i == 0) ? 8'h0f : (i == 1) ? 8'h01 : 8'(rnd() % 15 + 1);
			b = 8'(rnd());
			md = {i[0], i[0] & i[1]};
			mk_jis(k, m, b, 1'b0);
			rf_send(1'b0);
			tunnel({2'b00, b, 4'h0}, 8'(m * 16), i[0] ? 8'he8 : 8'hf8, 1'b1, i[1]);
		end
		for (int i = 0; i < 2; i++) begin
			p1 = 8'(rnd());
			p2 = 8'(rnd());
			le = 8'(rnd() % 251 + 1);
			fr = {`RHTC_CLA_OK, `RHTC_TB_READ, p1, p2, le};
			rf_send(1'b1);
			tunnel({p1[5:0], p2}, le, i[0] ? 8'he8 : 8'hf8, 1'b1, i[0]);
		end
		// Write codes reach the host
		fr = {`RHTC_JIS_WRITE, 8'h01, 8'h02, 8'h03};
		rf_send(1'b0);
		tunnel(14'h0000, 8'h00, 8'hf8, 1'b0, 1'b0);
		fr = {`RHTC_CLA_OK, `RHTC_TB_WRITE, 8'h00, 8'h10, 8'h01, 8'h5a};
		rf_send(1'b1);
		tunnel(14'h0000, 8'h00, 8'hf8, 1'b0, 1'b1);
		repeat (1000) @(negedge clk);
		chk8("no_timeout", 8'h00, 8'(tos));
		// Field faults answer error
		for (int i = 0; i < 7; i++) begin
			eq.delete();
			md = i[0] ? 2'b10 : 2'b00;
			case (i)
				0: mk_jis(8'h00, 8'h01, 8'h00, 1'b0);
				1: mk_jis(8'h10, 8'h01, 8'h00, 1'b0);
				2: mk_jis(8'h03, 8'h01, 8'h00, 1'b1);
				3: mk_jis(8'h01, 8'h00, 8'h00, 1'b0);
				4: mk_jis(8'h01, 8'h10, 8'h00, 1'b0);
				5: fr = {8'h01, `RHTC_TB_READ, 8'h00, 8'h00, 8'h10};
				default: fr = {8'hff, `RHTC_TB_READ, 8'h00, 8'h00, 8'h10};
			endcase
			rf_send(i > 4);
			wait_on(2, 1, 40);
			chk1("bad_err", 1'b1, eq[0]);
			chk1("bad_irq", 1'b0, seen);
		end
		// Unknown reader code is ignored
		fr = {8'h10, 8'h00};
		rf_send(1'b0);
		repeat (20) @(negedge clk);
		chk1("ign_irq", 1'b0, seen);
		// Inquiry wait expires past a stray command
		mk_jis(8'h01, 8'h01, 8'h22, 1'b0);
		rf_send(1'b0);
		wait_on(0, 0, 40);
		t0 = cyc;
		rq.delete();
		fr = {8'h55};
		h_send();
		wait_on(1, 1, 100);
		chk8("stray", `RHTC_STAT_BUSY, rq[0]);
		to_win(ql);
		// Result wait expires
		mk_jis(8'h02, 8'h03, 8'h40, 1'b0);
		rf_send(1'b0);
		wait_on(0, 0, 40);
		rq.delete();
		inq = 1'b1;
		@(negedge clk);
		inq = 1'b0;
		wait_on(1, 4, 200);
		t0 = cyc;
		to_win(al);
		wrap_up();
	end
endmodule : tb
